// ### design/bps_pkg.sv
// constants and types for the poll/select responder
package bps_pkg;
	localparam logic [7:0] NO_DEV_BYTE = 8'h7f;
	localparam logic [7:0] TERM_BYTE = 8'h2d;
	localparam logic [7:0] SEL_OFFSET = 8'h20;
	localparam logic [7:0] EXC_A_POLL = 8'hc1;
	localparam logic [7:0] EXC_A_SEL = 8'h61;
	localparam logic [7:0] EXC_B_POLL = 8'h50;
	localparam logic [7:0] EXC_B_SEL = 8'hf0;
	localparam logic [7:0] CLUSTER_RST = 8'h40;
	localparam int CLK_HZ = 100000000;
	localparam int DEADLINE_S = 3;
	localparam longint DEADLINE_CYC_L = longint'(CLK_HZ) * DEADLINE_S;
	localparam logic [31:0] DEADLINE_CYC = DEADLINE_CYC_L[31:0];
	typedef enum logic [2:0] {
		BPS_C1 = 3'b000,
		BPS_C2 = 3'b001,
		BPS_D1 = 3'b010,
		BPS_D2 = 3'b011,
		BPS_TERM = 3'b100
	} bps_state_t;
	typedef enum logic [1:0] {
		BPS_ANS_NONE = 2'b00,
		BPS_ANS_EOT = 2'b01,
		BPS_ANS_ACK = 2'b10,
		BPS_ANS_STAT = 2'b11
	} bps_ans_t;
endpackage

// ### design/bps_responder.sv
// poll and select recogniser with answer generation
`timescale 1ns/1ns
// Operation
// - answer every poll within three seconds
// - idle cluster answers general poll with eot
// - idle device answers specific poll with eot
// - select cluster byte is poll plus 20
// - c1 selects as 61, 50 as f0
// - ready selected device answers with ack
// - report attention status, device-return on recovery
// - honour reverse input hold from host
// - printer select starts call when enabled
module bps_responder
	import bps_pkg::*;
#(
	parameter int DEV_N = 32,
	parameter logic [31:0] DEADLINE = DEADLINE_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// received line bytes
	input wire logic [7:0] rx_byte,
	input wire logic rx_valid,
	// configuration
	input wire logic [7:0] cluster_addr,
	input wire logic autocall_en,
	// device side status, per device index (device byte low five bits)
	input wire logic [DEV_N-1:0] dev_pending,
	input wire logic [DEV_N-1:0] dev_ready,
	input wire logic [DEV_N-1:0] dev_failed,
	input wire logic [DEV_N-1:0] dev_is_printer,
	input wire logic reverse_input_hold,
	// answer to host
	output logic ans_valid,
	output bps_ans_t ans_kind,
	output logic [7:0] ans_dev,
	output logic operator_attention_status,
	output logic device_return_status,
	output logic input_held,
	output logic line_timeout,
	// call request to host_side_assembler
	output logic call_start,
	output logic [7:0] call_dev
);
	bps_state_t st_reg, st_next;
	logic sel_reg, sel_next;
	logic gen_reg, gen_next;
	logic [7:0] dev_reg, dev_next;
	logic ans_valid_next, att_next, ret_next, call_next;
	bps_ans_t kind_next;
	logic [7:0] ans_dev_next, call_dev_next;
	logic [DEV_N-1:0] att_reg, att_set_next;
	logic [31:0] tmr_reg, tmr_next;
	logic to_next;
	logic [7:0] sel_addr;
	logic [4:0] idx;
	logic att_out_reg, ret_out_reg;

	// select form of our cluster address
	always_comb begin
		if (cluster_addr == EXC_A_POLL)
			sel_addr = EXC_A_SEL;
		else if (cluster_addr == EXC_B_POLL)
			sel_addr = EXC_B_SEL;
		else
			sel_addr = cluster_addr + SEL_OFFSET;
	end

	assign idx = dev_reg[4:0];

	// sequence recognition and answer choice
	always_comb begin
		st_next = st_reg;
		sel_next = sel_reg;
		gen_next = gen_reg;
		dev_next = dev_reg;
		ans_valid_next = 1'b0;
		kind_next = BPS_ANS_NONE;
		ans_dev_next = ans_dev;
		att_next = 1'b0;
		ret_next = 1'b0;
		call_next = 1'b0;
		call_dev_next = call_dev;
		att_set_next = att_reg;
		// device failure latches attention; recovery queues device-return
		att_set_next = att_reg | dev_failed;
		if (rx_valid) begin
			case (st_reg)
			BPS_C1: begin
				if (rx_byte == cluster_addr) begin
					sel_next = 1'b0;
					st_next = BPS_C2;
				end else if (rx_byte == sel_addr) begin
					sel_next = 1'b1;
					st_next = BPS_C2;
				end
			end
			BPS_C2: begin
				if (rx_byte == (sel_reg ? sel_addr : cluster_addr))
					st_next = BPS_D1;
				else
					st_next = BPS_C1;
			end
			BPS_D1: begin
				dev_next = rx_byte;
				st_next = BPS_D2;
			end
			BPS_D2: begin
				gen_next = (rx_byte == NO_DEV_BYTE) && (dev_reg == NO_DEV_BYTE);
				st_next = (rx_byte == dev_reg) ? BPS_TERM : BPS_C1;
			end
			BPS_TERM: begin
				st_next = BPS_C1;
				if (rx_byte == TERM_BYTE) begin
					ans_valid_next = 1'b1;
					ans_dev_next = dev_reg;
					if (sel_reg) begin
						if (dev_ready[idx] && !att_reg[idx]) begin
							kind_next = BPS_ANS_ACK;
							if (autocall_en && dev_is_printer[idx]) begin
								call_next = 1'b1;
								call_dev_next = dev_reg;
							end
						end else begin
							kind_next = BPS_ANS_STAT;
							att_next = 1'b1;
						end
					end else if (gen_reg) begin
						if (|att_reg || |dev_pending)
							kind_next = BPS_ANS_STAT;
						else
							kind_next = BPS_ANS_EOT;
					end else if (reverse_input_hold) begin
						kind_next = BPS_ANS_EOT;
					end else if (att_reg[idx] && !dev_failed[idx]) begin
						kind_next = BPS_ANS_STAT;
						ret_next = 1'b1;
						att_set_next[idx] = 1'b0;
					end else if (att_reg[idx]) begin
						kind_next = BPS_ANS_STAT;
						att_next = 1'b1;
					end else if (dev_pending[idx]) begin
						kind_next = BPS_ANS_STAT;
					end else begin
						kind_next = BPS_ANS_EOT;
					end
				end
			end
			default: st_next = BPS_C1;
			endcase
		end
	end

	// response deadline watch: counts from first byte to answer
	always_comb begin
		tmr_next = tmr_reg;
		to_next = 1'b0;
		if (ans_valid_next || st_reg == BPS_C1)
			tmr_next = '0;
		else if (tmr_reg >= DEADLINE - 32'h1) begin
			tmr_next = '0;
			to_next = 1'b1;
		end else
			tmr_next = tmr_reg + 32'h1;
	end

	// state and output registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_reg <= BPS_C1;
			sel_reg <= 1'b0;
			gen_reg <= 1'b0;
			dev_reg <= 8'h00;
			att_reg <= '0;
			tmr_reg <= '0;
			ans_valid <= 1'b0;
			ans_kind <= BPS_ANS_NONE;
			ans_dev <= 8'h00;
			att_out_reg <= 1'b0;
			ret_out_reg <= 1'b0;
			line_timeout <= 1'b0;
			call_start <= 1'b0;
			call_dev <= 8'h00;
			input_held <= 1'b0;
		end else begin
			st_reg <= to_next ? BPS_C1 : st_next;
			sel_reg <= sel_next;
			gen_reg <= gen_next;
			dev_reg <= dev_next;
			att_reg <= att_set_next;
			tmr_reg <= tmr_next;
			ans_valid <= ans_valid_next;
			ans_kind <= kind_next;
			ans_dev <= ans_dev_next;
			att_out_reg <= att_next;
			ret_out_reg <= ret_next;
			line_timeout <= to_next;
			call_start <= call_next;
			call_dev <= call_dev_next;
			input_held <= reverse_input_hold;
		end
	end

	assign operator_attention_status = att_out_reg;
	assign device_return_status = ret_out_reg;

	// answer follows terminating byte by exactly one cycle
	property p_term_answer;
		@(posedge clk_sys) disable iff (!rst_n)
		(rx_valid && st_reg == BPS_TERM && rx_byte == TERM_BYTE)
			|=> ans_valid;
	endproperty
	a_term_answer: assert property (p_term_answer)
		else $error("terminated sequence not answered");

	property p_no_term;
		@(posedge clk_sys) disable iff (!rst_n)
		(rx_valid && st_reg == BPS_TERM && rx_byte != TERM_BYTE)
			|=> !ans_valid;
	endproperty
	a_no_term: assert property (p_no_term)
		else $error("answer without terminator");

	property p_ack_ready;
		@(posedge clk_sys) disable iff (!rst_n)
		(ans_valid && ans_kind == BPS_ANS_ACK) |-> $past(sel_reg);
	endproperty
	a_ack_ready: assert property (p_ack_ready)
		else $error("ack sent for non-select");

	property p_call;
		@(posedge clk_sys) disable iff (!rst_n)
		call_start |-> (ans_valid && ans_kind == BPS_ANS_ACK
			&& $past(autocall_en));
	endproperty
	a_call: assert property (p_call)
		else $error("call started without printer select");

	property p_timeout;
		@(posedge clk_sys) disable iff (!rst_n)
		line_timeout |-> $past(st_reg) != BPS_C1;
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("timeout while idle");

	property p_ret;
		@(posedge clk_sys) disable iff (!rst_n)
		device_return_status |-> ans_valid && ans_kind == BPS_ANS_STAT;
	endproperty
	a_ret: assert property (p_ret)
		else $error("device return without status answer");

	sequence s_gen_idle;
		rx_valid && st_reg == BPS_TERM && rx_byte == TERM_BYTE && gen_reg
			&& !sel_reg && att_reg == '0 && dev_pending == '0;
	endsequence
	property p_gen_eot;
		@(posedge clk_sys) disable iff (!rst_n)
		s_gen_idle |=> ans_kind == BPS_ANS_EOT;
	endproperty
	a_gen_eot: assert property (p_gen_eot)
		else $error("idle general poll not eot");

	property p_sel_map;
		@(posedge clk_sys) disable iff (!rst_n)
		(cluster_addr == EXC_A_POLL) |-> sel_addr == EXC_A_SEL;
	endproperty
	a_sel_map: assert property (p_sel_map)
		else $error("select mapping wrong");
endmodule

// ### bench/bps_host_model.sv
// host side model that sends poll and select sequences
`timescale 1ns/1ns
module bps_host_model (
	// clock
	input wire logic clk_sys,
	// line bytes to responder
	output logic [7:0] rx_byte,
	output logic rx_valid
);
	// line idles with no byte offered
	initial begin
		rx_byte = 8'h00;
		rx_valid = 1'b0;
	end
	// cluster pair, device pair, terminator; n limits bytes sent
	task automatic send(input logic [7:0] c, input logic [7:0] d,
		input logic [7:0] t, input int n);
		logic [7:0] seq [5];
		seq = '{c, c, d, d, t};
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			rx_valid <= 1'b1;
			rx_byte <= seq[i];
		end
		@(posedge clk_sys);
		rx_valid <= 1'b0;
		rx_byte <= ~seq[n-1]; // stale byte never left showing
	endtask
endmodule

// ### bench/tb_top.sv
// self-checking bench for the poll and select responder
`timescale 1ns/1ns
module tb_top;
	import bps_pkg::*;
	typedef struct packed {
		logic [7:0] ca;
		logic [7:0] c;
		logic [7:0] d;
		logic [7:0] t;
		logic [1:0] k;
	} bps_row_t;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] rx_byte, ans_dev, call_dev;
	logic [7:0] cluster_addr = 8'h40;
	logic rx_valid, autocall_en = 1'b0, reverse_input_hold = 1'b0;
	logic [31:0] dev_pending = '0, dev_ready = 32'h6;
	logic [31:0] dev_failed = 32'h0, dev_is_printer = 32'h4;
	logic ans_valid, operator_attention_status, device_return_status;
	logic input_held, line_timeout, call_start;
	// one-cycle pulses captured while the answer stands
	logic att_seen = 1'b0, ret_seen = 1'b0, call_seen = 1'b0;
	bps_ans_t ans_kind;
	int err_count = 0, n_tests = 0, cyc = 0;
	// cluster setting, sequence bytes, expected answer kind
	bps_row_t rows [8] = '{
		'{8'h40, 8'h40, 8'h7f, 8'h2d, 2'd1},
		'{8'h40, 8'h40, 8'h40, 8'h2d, 2'd1},
		'{8'h40, 8'h60, 8'h41, 8'h2d, 2'd2},
		'{8'hc1, 8'h61, 8'h41, 8'h2d, 2'd2},
		'{8'h50, 8'hf0, 8'h41, 8'h2d, 2'd2},
		'{8'h40, 8'h41, 8'h41, 8'h2d, 2'd0},
		'{8'h40, 8'h40, 8'h40, 8'h2e, 2'd0},
		'{8'hc1, 8'he1, 8'h41, 8'h2d, 2'd0}
	};
	bps_host_model h (.clk_sys, .rx_byte, .rx_valid);
	bps_responder #(.DEV_N(32), .DEADLINE(32'h64)) dut (.clk_sys, .rst_n,
		.rx_byte, .rx_valid, .cluster_addr, .autocall_en, .dev_pending,
		.dev_ready, .dev_failed, .dev_is_printer, .reverse_input_hold,
		.ans_valid, .ans_kind, .ans_dev, .operator_attention_status,
		.device_return_status, .input_held, .line_timeout, .call_start,
		.call_dev);
	// clock at 100 MHz
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic chk(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report();
		if (err_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// send a full sequence and check the answer in its one cycle
	task automatic run(input logic [7:0] c, input logic [7:0] d,
		input logic [7:0] t, input logic [1:0] k);
		h.send(c, d, t, 5);
		#1;
		att_seen = operator_attention_status;
		ret_seen = device_return_status;
		call_seen = call_start;
		chk("ans_valid", {7'h0, ans_valid}, {7'h0, k != 2'd0});
		if (k != 2'd0) begin
			chk("ans_kind", {6'h0, ans_kind}, {6'h0, k});
			chk("ans_dev", ans_dev, d);
		end
		@(posedge clk_sys);
	endtask
	// hang guard
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			final_report();
		end
	end
	// main sequence
	initial begin
		int i;
		repeat (11) @(posedge clk_sys);
		#1;
		chk("reset", {5'h0, ans_valid, line_timeout, call_start}, 8'h0);
		@(posedge clk_sys);
		rst_n <= 1'b1;
		foreach (rows[j]) begin
			@(posedge clk_sys);
			cluster_addr <= rows[j].ca;
			run(rows[j].c, rows[j].d, rows[j].t, rows[j].k);
		end
		cluster_addr <= 8'h40;
		dev_failed <= 32'h8;
		run(8'h40, 8'h43, 8'h2d, 2'd3);
		chk("attention", {7'h0, att_seen}, 8'h1);
		dev_failed <= '0;
		run(8'h40, 8'h43, 8'h2d, 2'd3);
		chk("return", {7'h0, ret_seen}, 8'h1);
		run(8'h60, 8'h40, 8'h2d, 2'd3);
		chk("sel_attention", {7'h0, att_seen}, 8'h1);
		dev_pending <= 32'h4;
		run(8'h40, 8'h7f, 8'h2d, 2'd3);
		run(8'h40, 8'h42, 8'h2d, 2'd3);
		reverse_input_hold <= 1'b1;
		run(8'h40, 8'h42, 8'h2d, 2'd1);
		chk("input_held", {7'h0, input_held}, 8'h1);
		reverse_input_hold <= 1'b0;
		dev_pending <= '0;
		autocall_en <= 1'b1;
		run(8'h60, 8'h42, 8'h2d, 2'd2);
		chk("call_start", {7'h0, call_seen}, 8'h1);
		chk("call_dev", call_dev, 8'h42);
		h.send(8'h40, 8'h40, 8'h2d, 2);
		i = 0;
		while (line_timeout !== 1'b1 && i < 150) begin
			@(posedge clk_sys);
			#1;
			i++;
		end
		chk("deadline", {7'h0, i > 90 && i < 110}, 8'h1);
		run(8'h40, 8'h40, 8'h2d, 2'd1);
		final_report();
	end
endmodule
